// ---- fdfw_pkg.sv ----
// Constants, register map and state types for the flying-die fire window control.
// Assumes a 50 MHz hclk and a single AHB-Lite slave port.
package fdfw_pkg;
    // Register byte offsets
    localparam logic [7:0] FDFW_CTRL_OFS    = 8'h00;
    localparam logic [7:0] FDFW_MIN_OFS     = 8'h04;
    localparam logic [7:0] FDFW_MAX_OFS     = 8'h08;
    localparam logic [7:0] FDFW_TOL_OFS     = 8'h0c;
    localparam logic [7:0] FDFW_ACCF_OFS    = 8'h10;
    localparam logic [7:0] FDFW_ACCR_OFS    = 8'h14;
    localparam logic [7:0] FDFW_MAXRV_OFS   = 8'h18;
    localparam logic [7:0] FDFW_PLEN_OFS    = 8'h1c;
    localparam logic [7:0] FDFW_DWELL_OFS   = 8'h20;
    localparam logic [7:0] FDFW_STAT_OFS    = 8'h24;
    localparam logic [7:0] FDFW_POS_OFS     = 8'h28;
    localparam logic [7:0] FDFW_ISTAT_OFS   = 8'h2c;
    localparam logic [7:0] FDFW_IMASK_OFS   = 8'h30;
    localparam logic [7:0] FDFW_CMD_OFS     = 8'h34;

    // Control register fields
    localparam int FDFW_CTRL_EN_BIT  = 0;
    localparam int FDFW_CTRL_REF_LSB = 1;
    localparam int FDFW_CTRL_TOL_LSB = 3;

    // Interrupt status bit positions
    localparam int FDFW_EV_FIRE    = 0;
    localparam int FDFW_EV_ABANDON = 1;
    localparam int FDFW_EV_LATE    = 2;
    localparam int FDFW_EV_TOLFAIL = 3;
    localparam int FDFW_EV_W       = 4;

    // Reset values
    localparam logic [4:0]  FDFW_CTRL_RST  = 5'h00;
    localparam logic [23:0] FDFW_MIN_RST   = 24'h000400;
    localparam logic [23:0] FDFW_MAX_RST   = 24'h000800;
    localparam logic [15:0] FDFW_TOL_RST   = 16'h0010;
    localparam logic [15:0] FDFW_ACC_RST   = 16'h0001;
    localparam logic [15:0] FDFW_MAXRV_RST = 16'h0010;
    localparam logic [23:0] FDFW_PLEN_RST  = 24'h002000;
    localparam logic [15:0] FDFW_DWELL_RST = 16'h0008;

    // Control period: the speed loop updates once per period
    localparam int FDFW_CLK_MHZ       = 50;
    localparam int FDFW_CTRL_PERIOD_NS = 1000;
    localparam int FDFW_TICK_CYC      = (FDFW_CTRL_PERIOD_NS * FDFW_CLK_MHZ) / 1000;

    // Full scale of the bipolar command equals +/-10 V at the converter
    localparam int FDFW_CMD_FS_VOLTS  = 10;
    localparam logic signed [15:0] FDFW_CMD_POS_FS = 16'sh7fff;
    localparam logic signed [15:0] FDFW_CMD_NEG_FS = -16'sh7fff;

    typedef enum logic [1:0] {FDFW_REF_MIN, FDFW_REF_MAX, FDFW_REF_HOME} fdfw_ref_t;
    typedef enum logic [1:0] {FDFW_TOL_CUT_STOP, FDFW_TOL_STOP_NO_CUT, FDFW_TOL_WARN} fdfw_tol_t;
    typedef enum logic [2:0] {FDFW_ST_IDLE, FDFW_ST_TRACK, FDFW_ST_DWELL, FDFW_ST_RETURN,
                              FDFW_ST_HALT} fdfw_state_t;
endpackage

// ---- fdfw_top.sv ----
// Flying-die fire window control: tracks the line, fires the press inside the window, returns home.
// Assumes encoder, switch and press inputs are synchronous to hclk and encoders step at most once per clock.
// Functional notes
// - Bipolar signed speed command, full scale ten volts
// - Reference point: minimum, maximum or home switch
// - Min or home reference: no fire before minimum
// - Never start press cycle beyond maximum distance
// - Gated modes: retest tolerance, fire once met
// - Tolerance unmet at maximum: abandon, flag error
// - Return capped, only as fast as needed
// - Flag error when return is too late
// - Tracking follows line speed, ignoring return cap
// - Forward and return use separate acceleration rates
// - Decelerate at preceding segment's acceleration rate
// - Tolerance compares line length against die length
// - Cut-and-stop: cut, check after dwell, halt line
//
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ns
module fdfw_top
    import fdfw_pkg::*;
(
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic      [31:0]        hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    input  wire logic               line_enc_a,
    input  wire logic               line_enc_b,
    input  wire logic               die_enc_a,
    input  wire logic               die_enc_b,
    input  wire logic               die_home,
    input  wire logic               target_due,
    input  wire logic               shear_done,
    output logic signed [15:0]      speed_cmd,
    output logic                    press_fire,
    output logic                    line_halt,
    output logic                    irq
);
    // Quadrature step: +1, -1 or 0 from previous and current A/B
    function automatic logic signed [1:0] qstep(input logic [1:0] prv, input logic [1:0] cur);
        logic [3:0] k;
        k = {prv, cur};
        unique case (k)
            4'b0001, 4'b0111, 4'b1110, 4'b1000: qstep = 2'sb01;
            4'b0010, 4'b1011, 4'b1101, 4'b0100: qstep = -2'sb01;
            default:                            qstep = 2'sb00;
        endcase
    endfunction

    // Move cur toward tgt by at most step
    function automatic logic signed [15:0] ramp(input logic signed [15:0] cur, input logic signed [15:0] tgt,
                                                input logic [15:0] step);
        logic signed [17:0] up;
        logic signed [17:0] dn;
        up = 18'(cur) + 18'(signed'({1'b0, step}));
        dn = 18'(cur) - 18'(signed'({1'b0, step}));
        if (cur < tgt) begin
            ramp = (up > 18'(tgt)) ? tgt : up[15:0];
        end else begin
            ramp = (dn < 18'(tgt)) ? tgt : dn[15:0];
        end
    endfunction

    // Bus registers
    logic [4:0]  ctrl_r;
    logic [23:0] min_r, max_r, plen_r;
    logic [15:0] tol_r, accf_r, accr_r, maxrv_r, dwell_r;
    logic [FDFW_EV_W-1:0] istat_r, imask_r;
    logic        ap_wr_r;
    logic [7:0]  ap_addr_r;
    logic [31:0] rdata_r;

    // Motion state
    fdfw_state_t state_r, state_nxt;
    logic [1:0]  lq_r, dq_r;
    logic signed [23:0] die_pos_r, line_len_r;
    logic [15:0] line_cnt_r;
    logic signed [15:0] line_v_r, vel_r, ret_v_r;
    logic [7:0]  tick_cnt_r;
    logic [15:0] dwell_cnt_r;
    logic        press_r, halt_r;

    wire ap_take   = hsel & htrans[1] & hready;
    wire dp_wr     = ap_wr_r;
    wire enable    = ctrl_r[FDFW_CTRL_EN_BIT];
    wire [1:0] ref_sel  = ctrl_r[FDFW_CTRL_REF_LSB +: 2];
    wire [1:0] tol_mode = ctrl_r[FDFW_CTRL_TOL_LSB +: 2];
    wire tick      = (tick_cnt_r == 8'(FDFW_TICK_CYC - 1));
    wire signed [1:0] lstep = qstep(lq_r, {line_enc_a, line_enc_b});
    wire signed [1:0] dstep = qstep(dq_r, {die_enc_a, die_enc_b});

    // Fire window decode, evaluated against the live position every cycle
    wire signed [24:0] pos_x   = 25'(die_pos_r);
    wire signed [24:0] min_x   = 25'(signed'({1'b0, min_r}));
    wire signed [24:0] max_x   = 25'(signed'({1'b0, max_r}));
    wire signed [24:0] ref_pt  = (ref_sel == FDFW_REF_MAX) ? max_x : min_x;
    wire at_ref     = (pos_x >= ref_pt);
    wire beyond_max = (pos_x > max_x);
    wire at_max     = (pos_x >= max_x);
    wire signed [24:0] tol_diff = 25'(line_len_r) - pos_x;
    wire [24:0] tol_abs = tol_diff[24] ? 25'(-tol_diff) : 25'(tol_diff);
    wire in_tol     = (tol_abs <= 25'(tol_r));
    wire gated      = (tol_mode == FDFW_TOL_STOP_NO_CUT) || (tol_mode == FDFW_TOL_WARN);
    wire fire_ok    = at_ref && !beyond_max && (!gated || in_tol);
    wire abandon    = gated && at_max && !in_tol && !fire_ok;
    wire dwell_end  = (dwell_cnt_r == 16'h0000) || shear_done;
    wire tol_fail   = (tol_mode == FDFW_TOL_CUT_STOP) && !in_tol;
    wire late       = target_due && (state_r != FDFW_ST_IDLE) && (state_r != FDFW_ST_HALT);

    // Return speed demand: grow when the die would not reach home before the next target
    wire signed [23:0] remain = 24'(signed'(plen_r)) - line_len_r;
    wire signed [40:0] need_l = 41'(die_pos_r) * 41'(line_v_r);
    wire signed [40:0] have_l = 41'(remain) * 41'(ret_v_r);
    wire signed [15:0] maxrv_s = signed'(maxrv_r);
    wire signed [15:0] ret_v_nxt = (need_l > have_l) ? ((ret_v_r < maxrv_s) ? ret_v_r + 16'sd1 : maxrv_s)
                                                     : ((ret_v_r > 16'sd1) ? ret_v_r - 16'sd1 : 16'sd1);

    // Velocity target per state
    logic signed [15:0] vel_tgt;
    always_comb begin
        unique case (state_r)
            FDFW_ST_TRACK, FDFW_ST_DWELL: vel_tgt = line_v_r;
            FDFW_ST_RETURN:               vel_tgt = die_home ? 16'sd0 : -ret_v_r;
            default:                      vel_tgt = 16'sd0;
        endcase
    end

    // The rate follows the direction of motion, so a stop reuses the rate that started the motion
    wire fwd_move = (vel_r > 16'sd0) || ((vel_r == 16'sd0) && (vel_tgt > 16'sd0));
    wire [15:0] seg_rate = fwd_move ? accf_r : accr_r;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            FDFW_ST_IDLE:   if (enable && target_due) state_nxt = FDFW_ST_TRACK;
            FDFW_ST_TRACK: begin
                if (fire_ok) begin
                    state_nxt = FDFW_ST_DWELL;
                end else if (abandon || beyond_max) begin
                    state_nxt = FDFW_ST_RETURN;
                end
            end
            FDFW_ST_DWELL: begin
                if (dwell_end) begin
                    state_nxt = tol_fail ? FDFW_ST_HALT : FDFW_ST_RETURN;
                end
            end
            FDFW_ST_RETURN: if (die_home) state_nxt = FDFW_ST_IDLE;
            FDFW_ST_HALT:   if (!enable) state_nxt = FDFW_ST_RETURN;
        endcase
    end

    wire entering_fwd = (state_r == FDFW_ST_IDLE) && (state_nxt == FDFW_ST_TRACK);
    wire [FDFW_EV_W-1:0] ev_set = {(state_r == FDFW_ST_DWELL) && dwell_end && tol_fail, late,
                                   (state_r == FDFW_ST_TRACK) && abandon && !fire_ok,
                                   (state_r == FDFW_ST_TRACK) && fire_ok};

    // AHB-Lite slave, zero wait: read data is captured in the address phase
    wire [7:0] a_ofs = haddr[7:0];
    wire [31:0] rd_mux =
        (a_ofs == FDFW_CTRL_OFS)  ? {27'h0, ctrl_r} :
        (a_ofs == FDFW_MIN_OFS)   ? {8'h0, min_r} :
        (a_ofs == FDFW_MAX_OFS)   ? {8'h0, max_r} :
        (a_ofs == FDFW_TOL_OFS)   ? {16'h0, tol_r} :
        (a_ofs == FDFW_ACCF_OFS)  ? {16'h0, accf_r} :
        (a_ofs == FDFW_ACCR_OFS)  ? {16'h0, accr_r} :
        (a_ofs == FDFW_MAXRV_OFS) ? {16'h0, maxrv_r} :
        (a_ofs == FDFW_PLEN_OFS)  ? {8'h0, plen_r} :
        (a_ofs == FDFW_DWELL_OFS) ? {16'h0, dwell_r} :
        (a_ofs == FDFW_STAT_OFS)  ? {26'h0, halt_r, press_r, die_home, 3'(state_r)} :
        (a_ofs == FDFW_POS_OFS)   ? {{8{die_pos_r[23]}}, die_pos_r} :
        (a_ofs == FDFW_ISTAT_OFS) ? {28'h0, istat_r} :
        (a_ofs == FDFW_IMASK_OFS) ? {28'h0, imask_r} :
        (a_ofs == FDFW_CMD_OFS)   ? {{16{vel_r[15]}}, vel_r} : 32'h0000_0000;
    wire wr_ctrl  = dp_wr && (ap_addr_r == FDFW_CTRL_OFS);
    wire wr_istat = dp_wr && (ap_addr_r == FDFW_ISTAT_OFS);

    assign hrdata    = rdata_r;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign speed_cmd = vel_r;
    assign press_fire = press_r;
    assign line_halt = halt_r;
    assign irq       = |(istat_r & imask_r);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_r   <= 1'b0;
            ap_addr_r <= 8'h00;
            rdata_r   <= 32'h0000_0000;
        end else begin
            ap_wr_r   <= ap_take && hwrite;
            ap_addr_r <= ap_take ? a_ofs : ap_addr_r;
            rdata_r   <= (ap_take && !hwrite) ? rd_mux : rdata_r;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r  <= FDFW_CTRL_RST;
            min_r   <= FDFW_MIN_RST;
            max_r   <= FDFW_MAX_RST;
            tol_r   <= FDFW_TOL_RST;
            accf_r  <= FDFW_ACC_RST;
            accr_r  <= FDFW_ACC_RST;
            maxrv_r <= FDFW_MAXRV_RST;
            plen_r  <= FDFW_PLEN_RST;
            dwell_r <= FDFW_DWELL_RST;
            imask_r <= '0;
        end else if (dp_wr) begin
            ctrl_r  <= wr_ctrl ? hwdata[4:0] : ctrl_r;
            min_r   <= (ap_addr_r == FDFW_MIN_OFS)   ? hwdata[23:0] : min_r;
            max_r   <= (ap_addr_r == FDFW_MAX_OFS)   ? hwdata[23:0] : max_r;
            tol_r   <= (ap_addr_r == FDFW_TOL_OFS)   ? hwdata[15:0] : tol_r;
            accf_r  <= (ap_addr_r == FDFW_ACCF_OFS)  ? hwdata[15:0] : accf_r;
            accr_r  <= (ap_addr_r == FDFW_ACCR_OFS)  ? hwdata[15:0] : accr_r;
            maxrv_r <= (ap_addr_r == FDFW_MAXRV_OFS) ? hwdata[15:0] : maxrv_r;
            plen_r  <= (ap_addr_r == FDFW_PLEN_OFS)  ? hwdata[23:0] : plen_r;
            dwell_r <= (ap_addr_r == FDFW_DWELL_OFS) ? hwdata[15:0] : dwell_r;
            imask_r <= (ap_addr_r == FDFW_IMASK_OFS) ? hwdata[FDFW_EV_W-1:0] : imask_r;
        end
    end

    // Sticky events: a new event wins over a same-cycle clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            istat_r <= '0;
        end else begin
            istat_r <= (istat_r & ~(wr_istat ? hwdata[FDFW_EV_W-1:0] : '0)) | ev_set;
        end
    end

    // Encoders and die position relative to home
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lq_r       <= 2'b00;
            dq_r       <= 2'b00;
            die_pos_r  <= '0;
            line_len_r <= '0;
            line_cnt_r <= '0;
            line_v_r   <= '0;
            tick_cnt_r <= '0;
        end else begin
            lq_r       <= {line_enc_a, line_enc_b};
            dq_r       <= {die_enc_a, die_enc_b};
            die_pos_r  <= die_home && (state_r == FDFW_ST_RETURN) ? 24'sd0 : die_pos_r + 24'(dstep);
            line_len_r <= entering_fwd ? 24'sd0 : line_len_r + 24'(lstep);
            tick_cnt_r <= tick ? 8'h00 : tick_cnt_r + 8'h01;
            line_cnt_r <= tick ? 16'(signed'(lstep)) : line_cnt_r + 16'(signed'(lstep));
            line_v_r   <= tick ? signed'(line_cnt_r) : line_v_r;
        end
    end

    // Motion sequencing updated every cycle; speed ramp updated once per control period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r     <= FDFW_ST_IDLE;
            vel_r       <= '0;
            ret_v_r     <= 16'sd1;
            dwell_cnt_r <= '0;
            press_r     <= 1'b0;
            halt_r      <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            vel_r       <= tick ? ramp(vel_r, vel_tgt, seg_rate) : vel_r;
            ret_v_r     <= (tick && state_r == FDFW_ST_RETURN) ? ret_v_nxt : ret_v_r;
            dwell_cnt_r <= (state_nxt == FDFW_ST_DWELL && state_r != FDFW_ST_DWELL) ? dwell_r :
                           ((tick && dwell_cnt_r != 16'h0000) ? dwell_cnt_r - 16'h0001 : dwell_cnt_r);
            press_r     <= (state_nxt == FDFW_ST_DWELL);
            halt_r      <= (state_nxt == FDFW_ST_HALT);
        end
    end

    a_no_fire_beyond: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(press_r) |-> $past(!beyond_max))
        else $error("Press started beyond maximum distance");
    a_no_fire_early: assert property (@(posedge hclk) disable iff (!hresetn)
        ($rose(press_r) && ref_sel != FDFW_REF_MAX) |-> $past(pos_x >= min_x))
        else $error("Press started before minimum distance");
    a_gated_tol: assert property (@(posedge hclk) disable iff (!hresetn)
        ($rose(press_r) && $past(gated)) |-> $past(in_tol))
        else $error("Gated mode fired out of tolerance");
    a_abandon_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_r == FDFW_ST_TRACK && abandon) |=> (istat_r[FDFW_EV_ABANDON] && state_r == FDFW_ST_RETURN))
        else $error("Abandon not flagged");
    a_return_cap: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_r == FDFW_ST_RETURN) |-> (ret_v_r <= maxrv_s || $changed(maxrv_r) || $past(ret_v_r) > ret_v_r))
        else $error("Return speed above cap");
    a_late_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        late |=> istat_r[FDFW_EV_LATE])
        else $error("Late return not flagged");
    a_ramp_step: assert property (@(posedge hclk) disable iff (!hresetn)
        (tick && vel_r > 16'sd0) |=> (vel_r == $past(vel_tgt) || vel_r - $past(vel_r) == $past(accf_r)
                                       || $past(vel_r) - vel_r == $past(accf_r)))
        else $error("Forward speed step differs from forward rate");
    a_seg_rate: assert property (@(posedge hclk) disable iff (!hresetn)
        (tick && vel_r < 16'sd0) |=> (vel_r == $past(vel_tgt) || vel_r - $past(vel_r) == $past(accr_r)
                                       || $past(vel_r) - vel_r == $past(accr_r)))
        else $error("Reverse speed step differs from return rate");
    a_halt_tol: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_r == FDFW_ST_DWELL && dwell_end && tol_fail) |=> (line_halt && istat_r[FDFW_EV_TOLFAIL]))
        else $error("Out of tolerance cut did not halt line");
    a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
        (|(ev_set & imask_r)) |=> irq)
        else $error("Unmasked event gave no interrupt");
endmodule

// ---- fdfw_plant.sv ----
// Plant model: servo drive with die, line encoder, home switch and shear.
// Assumes speed_cmd in counts per 50-cycle period; encoders step at most once per clock.
`timescale 1ns/1ns
module fdfw_plant #(
    parameter int SH = 100
) (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic signed [15:0] speed_cmd,
    input  wire logic               press_fire,
    input  wire logic               line_halt,
    input  wire logic        [7:0]  line_v,
    output logic                    line_enc_a,
    output logic                    line_enc_b,
    output logic                    die_enc_a,
    output logic                    die_enc_b,
    output logic                    die_home,
    output logic                    shear_done,
    output logic signed      [23:0] die_pos
);
    int         dacc, lacc, sh, t, u;
    logic [1:0] dq, lq;
    function automatic logic [1:0] step(logic [1:0] q, bit up);
        return up ? {q[0], ~q[1]} : {~q[0], q[1]};
    endfunction
    assign {die_enc_a, die_enc_b}   = dq;
    assign {line_enc_a, line_enc_b} = lq;
    // Home switch closes anywhere at or behind the home point
    assign die_home = (die_pos <= 0);
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dacc <= 0; lacc <= 0; sh <= 0; dq <= 2'b00; lq <= 2'b00; die_pos <= 0; shear_done <= 0;
        end else begin
            t = dacc + speed_cmd;
            u = line_halt ? lacc : lacc + line_v;
            if (t >= 50) begin
                t -= 50; dq <= step(dq, 1); die_pos <= die_pos + 1;
            end else if (t <= -50) begin
                t += 50; dq <= step(dq, 0); die_pos <= die_pos - 1;
            end
            if (u >= 50) begin
                u -= 50; lq <= step(lq, 1);
            end
            dacc <= t;
            lacc <= u;
            sh <= press_fire ? sh + 1 : 0;
            shear_done <= press_fire && sh >= SH;
        end
    end
endmodule

// ---- tb.sv ----
// Self-checking bench for the fire window control with a plant on the motion side.
// Assumes this bench is the only AHB-Lite master and hreadyout loops back to hready.
`timescale 1ns/1ns
module tb;
    import fdfw_pkg::*;
    localparam int          SH = 100;
    localparam int          ACCF_V = 2, ACCR_V = 1;
    localparam logic [23:0] MINV = 24'h40, MAXV = 24'h80;
    localparam logic [7:0]  OFS [13] = '{FDFW_CTRL_OFS, FDFW_MIN_OFS, FDFW_MAX_OFS, FDFW_TOL_OFS, FDFW_ACCF_OFS,
        FDFW_ACCR_OFS, FDFW_MAXRV_OFS, FDFW_PLEN_OFS, FDFW_DWELL_OFS, FDFW_ISTAT_OFS, FDFW_IMASK_OFS, FDFW_POS_OFS, 8'h3c};
    localparam logic [31:0] RV [13] = '{{27'h0, FDFW_CTRL_RST}, {8'h0, FDFW_MIN_RST}, {8'h0, FDFW_MAX_RST},
        {16'h0, FDFW_TOL_RST}, {16'h0, FDFW_ACC_RST}, {16'h0, FDFW_ACC_RST}, {16'h0, FDFW_MAXRV_RST},
        {8'h0, FDFW_PLEN_RST}, {16'h0, FDFW_DWELL_RST}, 32'h0, 32'h0, 32'h0, 32'h0};
    logic               hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, target_due = 0;
    logic        [31:0] haddr = 0, hwdata = 0, rd, lfsr = 32'h8f1bcaa9;
    logic        [1:0]  htrans = 0;
    logic        [7:0]  line_v = 0;
    logic signed [23:0] die_pos, fire_pos;
    logic signed [15:0] speed_cmd, max_spd = 0, prev_spd = 0;
    wire         [31:0] hrdata;
    wire                hready, hresp, lea, leb, dea, deb, die_home, shear_done, press_fire, line_halt, irq;
    int                 fail_count = 0, num_checks = 0, cyc = 0, pw = 0;
    bit                 fire_seen;

    always #10 hclk = ~hclk;

    fdfw_top fdfw_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
        .hrdata, .hreadyout(hready), .hresp, .line_enc_a(lea), .line_enc_b(leb), .die_enc_a(dea),
        .die_enc_b(deb), .die_home, .target_due, .shear_done, .speed_cmd, .press_fire, .line_halt, .irq);
    fdfw_plant #(.SH(SH)) fdfw_plant_inst (.hclk, .hresetn, .speed_cmd, .press_fire, .line_halt, .line_v,
        .line_enc_a(lea), .line_enc_b(leb), .die_enc_a(dea), .die_enc_b(deb), .die_home, .shear_done, .die_pos);

    function automatic logic [31:0] nxt(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Expected event bits of one target: [0] fire [1] abandon [2] late [3] tolerance fail
    function automatic logic [3:0] exp_ev(logic [1:0] md, logic [15:0] tl, bit late);
        if (tl != 0) return {1'b0, late, 2'b01};
        return (md == FDFW_TOL_CUT_STOP) ? 4'b1001 : 4'b0010;
    endfunction
    // Forward motion ramps at the forward rate both ways, reverse motion at the return rate
    function automatic bit step_ok(logic signed [15:0] p, logic signed [15:0] c);
        int lim;
        lim = (p > 0 || c > 0) ? ACCF_V : ACCR_V;
        return (c - p <= lim) && (p - c <= lim);
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chkf(input string n, input logic e, input logic g);
        chk(n, {31'h0, e}, {31'h0, g});
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic ahb(input bit wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1; haddr <= {24'h0, a}; htrans <= 2'b10; hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 0; htrans <= 2'b00; hwdata <= wr ? d : 32'h0;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic wait_state(input logic [2:0] a, input logic [2:0] b);
        int k;
        rd = 32'h7;
        for (k = 0; k < 4000 && rd[2:0] !== a && rd[2:0] !== b; k++) ahb(0, FDFW_STAT_OFS, 0, rd);
        if (k == 4000) chk("state_wait", {29'h0, a}, rd);
    endtask
    task automatic run(input logic [1:0] rf, input logic [1:0] md, input logic [15:0] tl, input bit late);
        logic [3:0] ev;
        lfsr = nxt(lfsr);
        line_v <= 8'd16 + {4'h0, lfsr[3:0]};
        ahb(1, FDFW_TOL_OFS, {16'h0, tl}, rd);
        ahb(1, FDFW_CTRL_OFS, {27'h0, md, rf, 1'b1}, rd);
        fire_seen = 0;
        ev = exp_ev(md, tl, late);
        @(posedge hclk) target_due <= 1;
        @(posedge hclk) target_due <= 0;
        if (late) begin
            repeat (20) @(posedge hclk);
            target_due <= 1;
            @(posedge hclk) target_due <= 0;
        end
        wait_state(3'd3, 3'd4);
        ahb(0, FDFW_ISTAT_OFS, 0, rd);
        chk("istat", {28'h0, ev}, rd);
        chkf("fired", ev[0], fire_seen);
        if (ev[0]) chkf("fire_lo", 1, fire_pos >= $signed({1'b0, (rf == 1) ? MAXV : MINV}));
        if (ev[0]) chkf("fire_hi", 1, fire_pos <= $signed({1'b0, MAXV}) + 2);
        chkf("irq_masked", ev[2], irq);
        if (ev[3]) chkf("halt", 1, line_halt);
        if (ev[3]) ahb(1, FDFW_CTRL_OFS, 32'h0, rd);
        ahb(1, FDFW_ISTAT_OFS, 32'hf, rd);
        wait_state(3'd0, 3'd0);
        chkf("irq_clear", 0, irq);
    endtask

    always @(posedge hclk) begin
        cyc++;
        if ($rose(press_fire)) begin
            fire_seen = 1;
            fire_pos = die_pos;
        end
        if ($fell(press_fire)) chkf("press_width", 1, pw <= SH + 3);
        pw = press_fire ? pw + 1 : 0;
        if (hresetn && speed_cmd !== prev_spd) begin
            chkf("cmd_range", 1, speed_cmd >= -16'sd4 && speed_cmd <= FDFW_CMD_POS_FS);
            if (!line_halt) chkf("accel_step", 1, step_ok(prev_spd, speed_cmd));
        end
        if (speed_cmd > max_spd) max_spd = speed_cmd;
        prev_spd = speed_cmd;
        if (cyc > 95000) begin
            fail_count++;
            finish_test();
        end
    end

    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1;
        ahb(1, 8'h3c, 32'hffffffff, rd);
        for (int i = 0; i < 13; i++) begin
            ahb(0, OFS[i], 0, rd);
            chk("reset_value", RV[i], rd);
        end
        ahb(1, FDFW_MIN_OFS, {8'h0, MINV}, rd);
        ahb(1, FDFW_MAX_OFS, {8'h0, MAXV}, rd);
        ahb(1, FDFW_ACCF_OFS, ACCF_V, rd);
        ahb(1, FDFW_ACCR_OFS, ACCR_V, rd);
        ahb(1, FDFW_MAXRV_OFS, 32'h4, rd);
        ahb(1, FDFW_PLEN_OFS, 32'h100, rd);
        ahb(1, FDFW_IMASK_OFS, 32'h4, rd);
        run(FDFW_REF_MIN, FDFW_TOL_CUT_STOP, 16'hffff, 1);
        run(FDFW_REF_MAX, FDFW_TOL_CUT_STOP, 16'hffff, 0);
        run(FDFW_REF_HOME, FDFW_TOL_CUT_STOP, 16'hffff, 0);
        run(FDFW_REF_MIN, FDFW_TOL_STOP_NO_CUT, 16'h0, 0);
        run(FDFW_REF_MIN, FDFW_TOL_WARN, 16'h0, 0);
        run(FDFW_REF_MIN, FDFW_TOL_CUT_STOP, 16'h0, 0);
        chkf("track_speed", 1, max_spd >= 16'sd15);
        finish_test();
    end
endmodule
